//--- hw/bcd_adjust_and_decrement_alu.sv
// decimal-adjust and decrement-file datapath with apb register access
//
// Notes on behaviour
// RULE_01 - low nibble over 9 or digit carry: add 6
// RULE_02 - high nibble adjusted too; only carry changes
// RULE_03 - decrement reads byte, subtracts one, delivers result
// RULE_04 - destination 0 gives working reg, 1 memory
// RULE_05 - access 0 access bank, 1 bank register
// RULE_06 - extended set, access 0, f<=95: indexed offset
// RULE_07 - decrement sets c, dc, n, ov, z
//
// Implementation choices: the APB register port and the register addresses.
`default_nettype none
`include "alu_cfg.svh"

module bcd_adjust_and_decrement_alu
   import alu_pkg::*;
(
   // clock, reset, enable
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr
);

   logic [7:0]  mem [0:`MEM_WORDS-1];

   cmd_t        cmd_reg,      cmd_next;
   logic        pend_reg,     pend_next;
   logic [7:0]  faddr_reg,    faddr_next;
   logic [3:0]  bank_select_register_reg, bank_select_register_next;
   logic [7:0]  wreg_reg,     wreg_next;
   flags_t      flags_reg,    flags_next;
   logic [11:0] idxbase_reg,  idxbase_next;
   logic [11:0] maddr_reg,    maddr_next;
   logic [11:0] lastaddr_reg, lastaddr_next;
   apb_resp_t   resp_reg,     resp_next;

   logic [11:0] eff_addr;
   logic [7:0]  operand;
   logic [7:0]  dec_result;
   logic [8:0]  adj_sum;
   logic        adj_carry;
   logic        mem_we;
   logic [11:0] mem_waddr;
   logic [7:0]  mem_wdata;
   logic        acc_wr;
   logic        hit;

   // effective operand address
   always_comb
   begin
      if (!cmd_reg.acc && cmd_reg.ext && faddr_reg <= `IDX_LIMIT)
         eff_addr = idxbase_reg + {4'h0, faddr_reg};                          // [RULE_06]
      else if (!cmd_reg.acc)
         eff_addr = (faddr_reg >= `ACC_SPLIT) ? {`ACC_HI_PAGE, faddr_reg}
                                              : {4'h0, faddr_reg};           // [RULE_05]
      else
         eff_addr = {bank_select_register_reg, faddr_reg};                    // [RULE_05]
   end

   assign operand    = mem[eff_addr];
   assign dec_result = operand - 8'h01;                                        // [RULE_03]

   // decimal adjust: low digit first, its carry may push the high digit over 9
   always_comb
   begin
      adj_sum = {1'b0, wreg_reg};
      if (wreg_reg[3:0] > `NIBBLE_MAX || flags_reg.dc)
         adj_sum = adj_sum + `BCD_FIX_LO;                                      // [RULE_01]
      if (adj_sum[7:4] > `NIBBLE_MAX || flags_reg.c || adj_sum[8])
         adj_sum = adj_sum + `BCD_FIX_HI;                                      // [RULE_02]
      adj_carry = flags_reg.c | adj_sum[8];
   end

   // apb decode: answer registered from the setup cycle, so access phase is one cycle
   assign acc_wr = psel && penable && pwrite && resp_reg.ready;

   always_comb
   begin
      hit = 1'b1;
      resp_next = '0;
      unique case (paddr)
         `OFS_CMD:
         begin
            resp_next.rdata[`CMD_OP_BIT]   = (cmd_reg.op == OP_DECR);
            resp_next.rdata[`CMD_DEST_BIT] = cmd_reg.dest;
            resp_next.rdata[`CMD_ACC_BIT]  = cmd_reg.acc;
            resp_next.rdata[`CMD_EXT_BIT]  = cmd_reg.ext;
            resp_next.rdata[`CMD_BUSY_BIT] = pend_reg;
         end
         `OFS_FADDR:    resp_next.rdata[7:0]  = faddr_reg;
         `OFS_BANK:     resp_next.rdata[3:0]  = bank_select_register_reg;
         `OFS_WREG:     resp_next.rdata[7:0]  = wreg_reg;
         `OFS_STATUS:   resp_next.rdata[4:0]  = flags_reg;
         `OFS_IDXBASE:  resp_next.rdata[11:0] = idxbase_reg;
         `OFS_MADDR:    resp_next.rdata[11:0] = maddr_reg;
         `OFS_MDATA:    resp_next.rdata[7:0]  = mem[maddr_reg];
         `OFS_LASTADDR: resp_next.rdata[11:0] = lastaddr_reg;
         default:       hit = 1'b0;
      endcase
      if (psel && !penable)
      begin
         resp_next.ready  = 1'b1;
         resp_next.slverr = !hit;
      end
      else
      begin
         resp_next = '0;
      end
   end

   // register next values; execution has priority over a software write
   always_comb
   begin
      cmd_next      = cmd_reg;
      pend_next     = 1'b0;
      faddr_next    = faddr_reg;
      bank_select_register_next = bank_select_register_reg;
      wreg_next     = wreg_reg;
      flags_next    = flags_reg;
      idxbase_next  = idxbase_reg;
      maddr_next    = maddr_reg;
      lastaddr_next = lastaddr_reg;
      if (acc_wr)
      begin
         unique case (paddr)
            `OFS_CMD:
            begin
               cmd_next.op   = pwdata[`CMD_OP_BIT] ? OP_DECR : OP_ADJUST;
               cmd_next.dest = pwdata[`CMD_DEST_BIT];
               cmd_next.acc  = pwdata[`CMD_ACC_BIT];
               cmd_next.ext  = pwdata[`CMD_EXT_BIT];
               pend_next     = 1'b1;
            end
            `OFS_FADDR:   faddr_next   = pwdata[7:0];
            `OFS_BANK:    bank_select_register_next = pwdata[3:0];
            `OFS_WREG:    wreg_next    = pwdata[7:0];
            `OFS_STATUS:  flags_next   = pwdata[4:0];
            `OFS_IDXBASE: idxbase_next = pwdata[11:0];
            `OFS_MADDR:   maddr_next   = pwdata[11:0];
            default:      ;
         endcase
      end
      if (pend_reg)
      begin
         if (cmd_reg.op == OP_ADJUST)
         begin
            wreg_next    = adj_sum[7:0];                                       // [RULE_02]
            flags_next.c = adj_carry;                                          // [RULE_02]
         end
         else
         begin
            lastaddr_next = eff_addr;
            if (!cmd_reg.dest)
               wreg_next = dec_result;                                         // [RULE_04]
            flags_next.c  = (operand != 8'h00);                                // [RULE_07]
            flags_next.dc = (operand[3:0] != 4'h0);                            // [RULE_07]
            flags_next.n  = dec_result[7];                                     // [RULE_07]
            flags_next.ov = (operand == 8'h80);                                // [RULE_07]
            flags_next.z  = (dec_result == 8'h00);                             // [RULE_07]
         end
      end
   end

   // memory write port: decrement write-back or software data window
   always_comb
   begin
      mem_we    = 1'b0;
      mem_waddr = maddr_reg;
      mem_wdata = pwdata[7:0];
      if (pend_reg && cmd_reg.op == OP_DECR && cmd_reg.dest)
      begin
         mem_we    = 1'b1;                                                     // [RULE_04]
         mem_waddr = eff_addr;
         mem_wdata = dec_result;
      end
      else if (acc_wr && paddr == `OFS_MDATA)
      begin
         mem_we = 1'b1;
      end
   end

   // memory is not reset: contents are undefined after power-up
   always_ff @(posedge pclk)
   begin
      if (ce && mem_we)
         mem[mem_waddr] <= mem_wdata;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cmd_reg      <= '{ext: `RST_EXT, acc: `RST_ACC, dest: `RST_DEST, op: OP_ADJUST};
         pend_reg     <= 1'b0;
         faddr_reg    <= 8'h00;
         bank_select_register_reg <= 4'h0;
         wreg_reg     <= 8'h00;
         flags_reg    <= '0;
         idxbase_reg  <= 12'h000;
         maddr_reg    <= 12'h000;
         lastaddr_reg <= 12'h000;
         resp_reg     <= '0;
      end
      else if (ce)
      begin
         cmd_reg      <= cmd_next;
         pend_reg     <= pend_next;
         faddr_reg    <= faddr_next;
         bank_select_register_reg <= bank_select_register_next;
         wreg_reg     <= wreg_next;
         flags_reg    <= flags_next;
         idxbase_reg  <= idxbase_next;
         maddr_reg    <= maddr_next;
         lastaddr_reg <= lastaddr_next;
         resp_reg     <= resp_next;
      end
   end

   assign prdata  = resp_reg.rdata;
   assign pready  = resp_reg.ready;
   assign pslverr = resp_reg.slverr;

endmodule
`default_nettype wire

//--- pkg/alu_cfg.svh
// offsets, field positions, reset values and limits of the adjust/decrement block
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH

`define OFS_CMD       12'h000
`define OFS_FADDR     12'h004
`define OFS_BANK      12'h008
`define OFS_WREG      12'h00c
`define OFS_STATUS    12'h010
`define OFS_IDXBASE   12'h014
`define OFS_MADDR     12'h018
`define OFS_MDATA     12'h01c
`define OFS_LASTADDR  12'h020

`define CMD_OP_BIT    0
`define CMD_DEST_BIT  1
`define CMD_ACC_BIT   2
`define CMD_EXT_BIT   3
`define CMD_BUSY_BIT  8

`define FLG_C_BIT     0
`define FLG_DC_BIT    1
`define FLG_Z_BIT     2
`define FLG_OV_BIT    3
`define FLG_N_BIT     4

`define RST_DEST      1'b1
`define RST_ACC       1'b1
`define RST_EXT       1'b0

`define NIBBLE_MAX    4'h9
`define BCD_FIX_LO    9'h006
`define BCD_FIX_HI    9'h060
`define IDX_LIMIT     8'h5f
`define ACC_SPLIT     8'h80
`define ACC_HI_PAGE   4'hf
`define MEM_WORDS     4096

`endif

//--- pkg/alu_pkg.sv
// types shared by the adjust/decrement datapath
`default_nettype none
package alu_pkg;

   typedef enum logic {
      OP_ADJUST,
      OP_DECR
   } op_t;

   typedef struct packed {
      logic ext;
      logic acc;
      logic dest;
      op_t  op;
   } cmd_t;

   typedef struct packed {
      logic n;
      logic ov;
      logic z;
      logic dc;
      logic c;
   } flags_t;

   typedef struct packed {
      logic [31:0] rdata;
      logic        ready;
      logic        slverr;
   } apb_resp_t;

endpackage
`default_nettype wire

//--- testbench/alu_assertions.sv
// apb answer checks for the adjust/decrement block
`default_nettype none
`include "alu_cfg.svh"
module alu_assertions
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        ce,
   // apb
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_after_setup: assert property (psel && !penable && ce |=> pready)
      else $error("no ready after setup");
   a_ready_has_cause: assert property (pready && ce && $past(ce) |-> $past(psel && !penable))
      else $error("ready without setup");
   a_err_needs_ready: assert property (pslverr |-> pready)
      else $error("error without ready");
   a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   a_wreg_one_byte: assert property (pready && !pwrite && paddr == `OFS_WREG |-> prdata[31:8] == 24'h0)
      else $error("working reg wider than a byte");
   a_flags_width: assert property (pready && !pwrite && paddr == `OFS_STATUS |-> prdata[31:5] == 27'h0)
      else $error("status has stray bits");
   a_map_err: assert property (pready && paddr > `OFS_LASTADDR |-> pslverr)
      else $error("unmapped access not refused");
   a_map_ok: assert property (pready && paddr <= `OFS_LASTADDR && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("mapped access refused");
endmodule
bind bcd_adjust_and_decrement_alu alu_assertions chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the adjust/decrement block
`default_nettype none
`include "alu_cfg.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        err;
   logic [31:0] rd;
   int          n_fail = 0;
   int          checked = 0;
   always #5 pclk = ~pclk;
   // ce stays high: freezing is outside the documented behaviour
   bcd_adjust_and_decrement_alu dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // other flags preset to 1 so a stray update shows
   task automatic adj(input logic [7:0] w, input logic c, dc, input logic [7:0] ew, input logic ec);
      xfer(1, `OFS_WREG, {24'h0, w});
      xfer(1, `OFS_STATUS, {27'h0, 3'b111, dc, c});
      xfer(1, `OFS_CMD, 32'h0);
      xfer(0, `OFS_WREG, 0);
      `CHK(rd[7:0], ew)
      xfer(0, `OFS_STATUS, 0);
      `CHK(rd[4:0], {3'b111, dc, ec})
   endtask
   task automatic dec(input logic ext, acc, dest, input logic [7:0] f, input logic [3:0] bank,
                      input logic [11:0] idx, ea, input logic [7:0] m);
      logic [7:0] r;
      r = m - 8'h01;
      xfer(1, `OFS_FADDR, {24'h0, f});
      xfer(1, `OFS_BANK, {28'h0, bank});
      xfer(1, `OFS_IDXBASE, {20'h0, idx});
      xfer(1, `OFS_MADDR, {20'h0, ea});
      xfer(1, `OFS_MDATA, {24'h0, m});
      xfer(1, `OFS_WREG, 32'h55);
      xfer(1, `OFS_STATUS, 32'h0);
      xfer(1, `OFS_CMD, {28'h0, ext, acc, dest, 1'b1});
      xfer(0, `OFS_WREG, 0);
      `CHK(rd[7:0], dest ? 8'h55 : r)
      xfer(0, `OFS_MDATA, 0);
      `CHK(rd[7:0], dest ? r : m)
      xfer(0, `OFS_LASTADDR, 0);
      `CHK(rd[11:0], ea)
      xfer(0, `OFS_STATUS, 0);
      `CHK(rd[4:0], {r[7], m == 8'h80, r == 8'h00, m[3:0] != 4'h0, m != 8'h00})
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      xfer(0, `OFS_CMD, 0);
      `CHK(rd, 32'h6)
      xfer(0, 12'h024, 0);
      `CHK({err, rd}, {1'b1, 32'h0})
      adj(8'ha5, 0, 0, 8'h05, 1);
      adj(8'hce, 0, 0, 8'h34, 1);
      adj(8'h13, 0, 1, 8'h19, 0);
      adj(8'h09, 0, 0, 8'h09, 0);
      adj(8'h9a, 0, 0, 8'h00, 1);
      adj(8'h45, 1, 0, 8'ha5, 1);
      dec(0, 1, 1, 8'h34, 4'h3, 12'h000, 12'h334, 8'h01);
      dec(0, 1, 0, 8'hff, 4'hf, 12'h000, 12'hfff, 8'h00);
      dec(0, 0, 1, 8'h10, 4'h5, 12'h000, 12'h010, 8'h80);
      dec(0, 0, 0, 8'h90, 4'h5, 12'h000, 12'hf90, 8'h10);
      dec(1, 0, 1, 8'h5f, 4'h5, 12'hfb0, 12'h00f, 8'h22);
      dec(1, 0, 1, 8'h60, 4'h5, 12'h200, 12'h060, 8'h05);
      dec(1, 1, 1, 8'h20, 4'h2, 12'h300, 12'h220, 8'hff);
      conclude();
   end
   // about 350 cycles expected
   initial
   begin
      repeat (5000) @(posedge pclk);
      n_fail++;
      conclude();
   end
endmodule
`default_nettype wire
